//--- hw/acs_pkg.sv
// Constants and types shared by the sample buffer and the output register block.
// Assumes one clock domain and byte-wide register access from the serial front end.
package acs_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_X_LO = 8'h32;
  localparam logic [7:0] ADDR_X_HI = 8'h33;
  localparam logic [7:0] ADDR_Y_LO = 8'h34;
  localparam logic [7:0] ADDR_Y_HI = 8'h35;
  localparam logic [7:0] ADDR_Z_LO = 8'h36;
  localparam logic [7:0] ADDR_Z_HI = 8'h37;
  localparam logic [7:0] ADDR_CTRL = 8'h38;

  // Buffer control fields
  localparam int         MODE_POS    = 6;
  localparam int         TRIG_POS    = 5;
  localparam int         SAMPLES_POS = 0;
  localparam int         SAMPLES_W   = 5;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Output format control fields (register kept outside this block)
  localparam int         FMT_RANGE_POS    = 0;
  localparam int         FMT_JUSTIFY_POS  = 2;
  localparam int         FMT_FULL_RES_POS = 3;
  localparam logic [4:0] FMT_BASE_SHIFT   = 5'h06;

  // Sizes
  localparam int BUF_DEPTH = 32;
  localparam int AXIS_W    = 16;
  localparam int ENTRY_W   = 3 * AXIS_W;
  localparam int COUNT_W   = 6;

  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'h0,
    MODE_FILL    = 2'h1,
    MODE_STREAM  = 2'h2,
    MODE_TRIGGER = 2'h3
  } acs_mode_t;

  typedef enum logic [1:0] {
    TRG_ARMED = 2'h1,
    TRG_FIRED = 2'h2
  } acs_trg_t;
endpackage

//--- hw/acs_buf_if.sv
// Carrier between the register block and the sample buffer.
// Assumes both ends sit on the same clock.
interface acs_buf_if #(
  parameter int W  = 48,
  parameter int CW = 6
);
  logic          push;
  logic [W-1:0]  push_data;
  logic          pop;
  logic          flush;
  logic [W-1:0]  pop_data;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;

  modport ctrl  (output push, push_data, pop, flush, input pop_data, count, full, empty);
  modport store (input push, push_data, pop, flush, output pop_data, count, full, empty);
endinterface

//--- hw/acs_sample_buf.sv
// Flip-flop sample store, oldest entry at the read pointer.
// Assumes the controller never pushes into a full store without popping in the same cycle.
module acs_sample_buf #(
  parameter int W     = 48,
  parameter int DEPTH = 32,
  parameter int CW    = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controller side
  acs_buf_if.store bus
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [CW-1:0] cnt_q;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire logic do_pop  = bus.pop && (cnt_q != '0);
  // A pop in the same cycle frees the slot, so a full store can still take a push
  wire logic do_push = bus.push && ((cnt_q != CW'(DEPTH)) || do_pop);

  assign bus.pop_data = mem_q[rd_q];
  assign bus.count    = cnt_q;
  assign bus.full     = (cnt_q == CW'(DEPTH));
  assign bus.empty    = (cnt_q == '0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else if (bus.flush) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_pop) rd_q <= next_ptr(rd_q);
      if (do_push) wr_q <= next_ptr(wr_q);
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  // Storage has no reset; contents are only read behind the count
  always_ff @(posedge clk) begin
    if (do_push) mem_q[wr_q] <= bus.push_data;
  end

  a_count_limit: assert property (@(posedge clk) disable iff (!rst_b)
    cnt_q <= CW'(DEPTH)) else $error("Sample store count above depth");

  a_push_counts: assert property (@(posedge clk) disable iff (!rst_b)
    (do_push && !do_pop && !bus.flush) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("Push did not raise the count by one");
endmodule

//--- hw/acs_top.sv
// Axis output registers and sample buffer control of the acceleration sensor.
// Assumes a byte register port from the serial front end and on-chip interrupt lines on REF_CLK.
module acs_top (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // Output format control
  input  wire logic [7:0]  FMT_CTRL,
  // Conversion results, right-justified and sign-extended
  input  wire logic        SMP_VALID,
  input  wire logic [15:0] SMP_X,
  input  wire logic [15:0] SMP_Y,
  input  wire logic [15:0] SMP_Z,
  // Trigger sources
  input  wire logic        IRQ_LINE_ONE,
  input  wire logic        IRQ_LINE_TWO,
  // Status
  output logic             DATA_READY,
  output logic             WATERMARK,
  output logic             OVERRUN,
  output logic             TRIGGERED,
  output logic      [5:0]  ENTRY_COUNT
);
  localparam int W  = acs_pkg::ENTRY_W;
  localparam int CW = acs_pkg::COUNT_W;

  acs_buf_if #(.W(W), .CW(CW)) buf_if ();

  acs_sample_buf #(.W(W), .DEPTH(acs_pkg::BUF_DEPTH), .CW(CW)) u_buf (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .bus   (buf_if.store)
  );

  logic [7:0]        ctrl_q;
  logic [W-1:0]      out_q;
  logic              out_valid_q;
  logic              wm_q;
  logic              ovr_q;
  logic              trig_sel_q;
  logic [7:0]        rdata_q;
  acs_pkg::acs_trg_t trg_q;
  acs_pkg::acs_trg_t trg_d;

  // Left-justify moves the sign bit to bit 15; the shift depends on the active resolution
  function automatic logic [15:0] fmt_axis(input logic [15:0] raw, input logic [7:0] fmt);
    logic [4:0] sh;
    sh = acs_pkg::FMT_BASE_SHIFT;
    if (fmt[acs_pkg::FMT_FULL_RES_POS]) sh = sh - {3'h0, fmt[acs_pkg::FMT_RANGE_POS +: 2]};
    return fmt[acs_pkg::FMT_JUSTIFY_POS] ? (raw << sh) : raw;
  endfunction

  // Control field decode
  wire acs_pkg::acs_mode_t mode = acs_pkg::acs_mode_t'(ctrl_q[acs_pkg::MODE_POS +: 2]);
  wire logic [4:0] samples      = ctrl_q[acs_pkg::SAMPLES_POS +: acs_pkg::SAMPLES_W];
  wire logic       trig_sel     = ctrl_q[acs_pkg::TRIG_POS];
  wire logic       buffered     = (mode != acs_pkg::MODE_BYPASS);
  wire logic       ctrl_wr      = REG_WR && (REG_ADDR == acs_pkg::ADDR_CTRL);
  wire logic       zero_wr      = ctrl_wr && (REG_WDATA[acs_pkg::SAMPLES_POS +: acs_pkg::SAMPLES_W] == 5'h00);
  wire logic       data_rd      = REG_RD && (REG_ADDR >= acs_pkg::ADDR_X_LO) && (REG_ADDR <= acs_pkg::ADDR_Z_HI);
  // The last byte of the burst retires the sample, so in the buffered modes the earlier bytes stay coherent
  wire logic       consume      = REG_RD && (REG_ADDR == acs_pkg::ADDR_Z_HI) && out_valid_q;

  // Incoming sample in output layout
  wire logic [W-1:0] smp_fmt = {fmt_axis(SMP_Z, FMT_CTRL), fmt_axis(SMP_Y, FMT_CTRL),
                                fmt_axis(SMP_X, FMT_CTRL)};

  // Trigger edge on the selected line
  wire logic trig_line = trig_sel ? IRQ_LINE_TWO : IRQ_LINE_ONE;
  wire logic trig_edge = trig_line && !trig_sel_q;

  // Buffer steering
  wire logic armed    = (mode == acs_pkg::MODE_TRIGGER) && (trg_q == acs_pkg::TRG_ARMED);
  wire logic keep_new = (mode == acs_pkg::MODE_STREAM) || armed;
  wire logic stop_new = (mode == acs_pkg::MODE_FILL) || ((mode == acs_pkg::MODE_TRIGGER) && !armed);
  wire logic pre_full = armed && (buf_if.count >= {1'b0, samples});
  wire logic load     = buffered && !buf_if.empty && (!out_valid_q || consume);
  wire logic overwrite = SMP_VALID && keep_new && !load && (buf_if.full || pre_full);
  wire logic dropped  = SMP_VALID && stop_new && buf_if.full && !load;
  wire logic byp_ovr  = SMP_VALID && !buffered && out_valid_q && !consume;
  wire logic wm_cond  = buffered && (samples != 5'h00) && (buf_if.count >= {1'b0, samples});

  assign buf_if.push      = SMP_VALID && buffered && !(stop_new && buf_if.full && !load);
  assign buf_if.push_data = smp_fmt;
  assign buf_if.pop       = load || overwrite;
  assign buf_if.flush     = ctrl_wr && (REG_WDATA[acs_pkg::MODE_POS +: 2] == 2'h0);

  // Register read selection
  wire logic [7:0] rd_mux =
    (REG_ADDR == acs_pkg::ADDR_X_LO) ? out_q[7:0]   :
    (REG_ADDR == acs_pkg::ADDR_X_HI) ? out_q[15:8]  :
    (REG_ADDR == acs_pkg::ADDR_Y_LO) ? out_q[23:16] :
    (REG_ADDR == acs_pkg::ADDR_Y_HI) ? out_q[31:24] :
    (REG_ADDR == acs_pkg::ADDR_Z_LO) ? out_q[39:32] :
    (REG_ADDR == acs_pkg::ADDR_Z_HI) ? out_q[47:40] :
    (REG_ADDR == acs_pkg::ADDR_CTRL) ? ctrl_q       : 8'h00;

  always_comb begin
    trg_d = trg_q;
    unique case (trg_q)
      acs_pkg::TRG_ARMED: if ((mode == acs_pkg::MODE_TRIGGER) && trig_edge) trg_d = acs_pkg::TRG_FIRED;
      acs_pkg::TRG_FIRED: if (ctrl_wr) trg_d = acs_pkg::TRG_ARMED;
      default:            trg_d = acs_pkg::TRG_ARMED;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q     <= acs_pkg::CTRL_RESET;
      trg_q      <= acs_pkg::TRG_ARMED;
      trig_sel_q <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      if (ctrl_wr) ctrl_q <= REG_WDATA;
      trg_q      <= trg_d;
      trig_sel_q <= trig_line;
      if (REG_RD) rdata_q <= rd_mux;
    end
  end

  // Output sample registers
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_q       <= '0;
      out_valid_q <= 1'b0;
    end else if (!buffered && SMP_VALID) begin
      out_q       <= smp_fmt;
      out_valid_q <= 1'b1;
    end else if (load) begin
      out_q       <= buf_if.pop_data;
      out_valid_q <= 1'b1;
    end else if (consume) begin
      out_valid_q <= 1'b0;
    end
  end

  // Status flags: a set in the same cycle as a read wins
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wm_q  <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (wm_cond || zero_wr) wm_q <= 1'b1;
      else if (data_rd) wm_q <= 1'b0;
      if (overwrite || dropped || byp_ovr) ovr_q <= 1'b1;
      else if (data_rd) ovr_q <= 1'b0;
    end
  end

  assign REG_RDATA   = rdata_q;
  assign DATA_READY  = out_valid_q;
  assign WATERMARK   = wm_q;
  assign OVERRUN     = ovr_q;
  assign TRIGGERED   = (trg_q == acs_pkg::TRG_FIRED);
  assign ENTRY_COUNT = buf_if.count;

  a_bypass_load: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (SMP_VALID && !buffered) |=> (out_q == $past(smp_fmt)) && DATA_READY)
    else $error("Bypass sample not presented");

  a_fill_stops: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (mode == acs_pkg::MODE_FILL && buf_if.full && SMP_VALID && !load && !ctrl_wr)
      |=> buf_if.full && OVERRUN)
    else $error("Full buffer in fill mode took a sample");

  a_stream_over: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (mode == acs_pkg::MODE_STREAM && buf_if.full && SMP_VALID && !load && !ctrl_wr)
      |=> (ENTRY_COUNT == 6'h20) && OVERRUN)
    else $error("Stream mode did not keep the latest 32 samples");

  a_trig_fires: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (armed && trig_edge && !ctrl_wr) |=> TRIGGERED ##1 TRIGGERED)
    else $error("Trigger edge on the selected line not taken");

  a_zero_wmark: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    zero_wr |=> WATERMARK)
    else $error("Zero sample count did not set watermark");

  a_level_wmark: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (mode == acs_pkg::MODE_FILL || mode == acs_pkg::MODE_STREAM) && wm_cond |=> WATERMARK)
    else $error("Watermark missing at programmed fill level");

  a_low_first: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_RD && REG_ADDR == acs_pkg::ADDR_X_LO) |=> REG_RDATA == $past(out_q[7:0]))
    else $error("X low byte not at the lower address");

  a_ctrl_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_RD && REG_ADDR == acs_pkg::ADDR_CTRL) |=> REG_RDATA == $past(ctrl_q))
    else $error("Buffer control readback wrong");

  a_ready_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (consume && buf_if.empty && !SMP_VALID) |=> !DATA_READY)
    else $error("Data ready not cleared by the final data read");
endmodule

//--- verification/acs_host.sv
// Host processor model on the byte register port of the sensor.
// Assumes it is called 1 ns after a rising edge of clk.
module acs_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Zero sample count is never written in trigger mode
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // Data is only qualified by the strobe
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // All six axis bytes back to back; in the buffered modes a new sample cannot split them
  task automatic burst(output logic [47:0] b);
    for (int i = 0; i < 6; i++) begin
      reg_addr = acs_pkg::ADDR_X_LO + 8'(i);
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      b[8*i +: 8] = reg_rdata;
    end
    reg_rd = 1'b0;
  endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the axis registers and sample buffer.
// Assumes the host model in acs_host drives the register port.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_b, smp_valid, irq_one, irq_two, wr, rd;
  logic        data_ready, watermark, overrun, triggered;
  logic [7:0]  addr, wdata, rdata, fmt_ctrl;
  logic [15:0] smp_x, smp_y, smp_z;
  logic [5:0]  entry_count;
  int          failures = 0;
  int          comparisons = 0;

  acs_top dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata), .FMT_CTRL(fmt_ctrl), .SMP_VALID(smp_valid), .SMP_X(smp_x),
    .SMP_Y(smp_y), .SMP_Z(smp_z), .IRQ_LINE_ONE(irq_one), .IRQ_LINE_TWO(irq_two),
    .DATA_READY(data_ready), .WATERMARK(watermark), .OVERRUN(overrun), .TRIGGERED(triggered),
    .ENTRY_COUNT(entry_count));
  acs_host host_u (.clk(ref_clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkb(input logic f, input logic e);
    chk({7'h00, f}, {7'h00, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Back-to-back samples; y and z are derived from x
  task automatic push(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      smp_x = base + 16'(i);
      smp_y = ~smp_x;
      smp_z = 16'h8000 | smp_x;
      smp_valid = 1'b1;
      tick(1);
    end
    smp_valid = 1'b0;
    tick(3);
  endtask

  function automatic logic [47:0] ex(input logic [15:0] x, input int sh);
    return {16'((16'h8000 | x) << sh), 16'((~x) << sh), 16'(x << sh)};
  endfunction

  task automatic wait_rdy();
    int k;
    k = 0;
    while (data_ready !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    if (data_ready !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic chk_data(input logic [47:0] e);
    logic [47:0] b;
    host_u.burst(b);
    for (int i = 0; i < 6; i++) chk(b[8*i +: 8], e[8*i +: 8]);
  endtask

  // Bypass mode and flush leave nothing stored; the burst read clears the presented sample
  task automatic clean();
    logic [47:0] b;
    host_u.wr(acs_pkg::ADDR_CTRL, 8'h00);
    host_u.burst(b);
    tick(2);
  endtask

  task automatic s_bypass();
    logic [7:0] d;
    host_u.wr(acs_pkg::ADDR_CTRL, 8'h00);
    tick(1);
    chkb(watermark, 1'b1);
    push(1, 16'hFFFB);
    wait_rdy();
    chk({2'h0, entry_count}, 8'h00);
    chk_data(ex(16'hFFFB, 0));
    chkb(data_ready, 1'b0);
    chkb(watermark, 1'b0);
    push(2, 16'h0010);
    chkb(overrun, 1'b1);
    clean();
    chkb(overrun, 1'b0);
    host_u.rd(8'h3A, d);
    chk(d, 8'h00);
  endtask

  task automatic s_format();
    fmt_ctrl = 8'h04;
    push(1, 16'h0001);
    wait_rdy();
    chk_data(ex(16'h0001, 6));
    fmt_ctrl = 8'h0F;
    push(1, 16'h0003);
    wait_rdy();
    chk_data(ex(16'h0003, 3));
    fmt_ctrl = 8'h00;
  endtask

  task automatic s_fill();
    host_u.wr(acs_pkg::ADDR_CTRL, 8'h44);
    tick(1);
    chkb(watermark, 1'b0);
    push(33, 16'h0100);
    chk({2'h0, entry_count}, 8'h20);
    chkb(overrun, 1'b0);
    chkb(watermark, 1'b1);
    push(1, 16'h0200);
    chkb(overrun, 1'b1);
    chk_data(ex(16'h0100, 0));
    tick(2);
    chkb(overrun, 1'b0);
    chk({2'h0, entry_count}, 8'h1F);
    push(1, 16'h0300);
    chk({2'h0, entry_count}, 8'h20);
    clean();
  endtask

  task automatic s_stream();
    host_u.wr(acs_pkg::ADDR_CTRL, 8'h90);
    push(35, 16'h0400);
    chk({2'h0, entry_count}, 8'h20);
    chkb(overrun, 1'b1);
    chkb(watermark, 1'b1);
    chk_data(ex(16'h0400, 0));
    tick(2);
    chk_data(ex(16'h0403, 0));
    clean();
  endtask

  task automatic s_trigger();
    logic [7:0] d;
    host_u.wr(acs_pkg::ADDR_CTRL, 8'hE4);
    host_u.rd(acs_pkg::ADDR_CTRL, d);
    chk(d, 8'hE4);
    push(10, 16'h0500);
    chk({2'h0, entry_count}, 8'h04);
    chkb(overrun, 1'b1);
    irq_one = 1'b1;
    tick(1);
    irq_one = 1'b0;
    tick(3);
    chkb(triggered, 1'b0);
    irq_two = 1'b1;
    tick(1);
    irq_two = 1'b0;
    tick(3);
    chkb(triggered, 1'b1);
    // Clear the pre-trigger overrun so the drop below is seen on its own
    chk_data(ex(16'h0500, 0));
    chkb(overrun, 1'b0);
    push(30, 16'h0600);
    chk({2'h0, entry_count}, 8'h20);
    chkb(overrun, 1'b1);
    chk_data(ex(16'h0506, 0));
    tick(2);
    chk_data(ex(16'h0507, 0));
  endtask

  initial begin
    rst_b = 1'b0;
    fmt_ctrl = 8'h00;
    smp_valid = 1'b0;
    smp_x = 16'h0000;
    smp_y = 16'h0000;
    smp_z = 16'h0000;
    irq_one = 1'b0;
    irq_two = 1'b0;
    tick(16);
    rst_b = 1'b1;
    tick(1);
    chkb(data_ready, 1'b0);
    chk({2'h0, entry_count}, 8'h00);
    s_bypass();
    s_format();
    s_fill();
    s_stream();
    s_trigger();
    wrap_up();
  end
endmodule
